// >>> design/disk_read_error_recovery.sv
// read error recovery sequencer: decides per sector between on-the-fly fix,
// rereads, double burst correction, reallocation and bad marking
// assumes the read channel returns fresh and stored check bytes per read and
// an external analyser reports per-interleave error extent for each syndrome
//
// How it works
// - more than two bytes per interleave: uncorrectable
// - one byte per interleave, 24 bits: on-the-fly
// - on-the-fly decision bounded by 200 us
// - reread up to limit before double burst
// - each reread: fresh syndromes, zero transfers, else retry
// - identical consecutive syndrome sets mean stable
// - early correction corrects on stable syndrome
// - early correction: reread while unstable or uncorrectable
// - auto read reallocation: three groups of eight
// - second group: correct and reallocate on stable
// - third group: reallocate on stable or correctable
// - uncorrectable after 24: mark bad, move data
// - zero retries means no rereads; default eight
// - correction disabled: deliver raw, on-the-fly unaffected
// - read continuous skips all recovery except on-the-fly correction
// - auto write reallocation spares unwritable blocks
// - repeated bad syndrome is hard error, reallocate
// - failed correction: store data, flag identification field
// - inline sparing for four defects per cylinder
// - grown defects never inline spared
// - fourteen syndromes from fresh versus stored check bytes
`timescale 1ns/1ns
module disk_read_error_recovery #(
  parameter int DECIDE_CYCLES = err_recov_pkg::DECIDE_CYC
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic readDone,
  input wire logic [err_recov_pkg::SYN_W-1:0] freshCheck,
  input wire logic [err_recov_pkg::SYN_W-1:0] storedCheck,
  input wire logic anaValid,
  input wire logic [1:0] ilvMaxBytes,
  input wire logic [6:0] errBits,
  input wire logic writeFail,
  input wire logic factoryDefect,
  input wire logic cylinderNew,
  output logic rereadReq,
  output logic corrReq,
  output logic [1:0] corrKind,
  output logic spareReq,
  output logic spareInline,
  output logic spareGrown,
  output logic spareBad,
  output logic outValid,
  output logic [2:0] outCode,
  output logic [err_recov_pkg::SYN_W-1:0] syndrome
);
  ////////////////////////////////////////////////////////////////////////////
  // register slave
  logic [12:0] cfg_q;
  logic [3:0] awAddr_q;
  logic awHeld_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic wHeld_q;
  logic [15:0] reallocCnt_q;
  err_recov_pkg::state_t state_q;
  err_recov_pkg::outcome_t lastOut_q;
  logic [7:0] n_q;

  assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= '0;
      wData_q <= '0;
      wStrb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= err_recov_pkg::RESP_OKAY;
      cfg_q <= err_recov_pkg::CFG_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (awHeld_q && wHeld_q) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awAddr_q == err_recov_pkg::CFG_OFS) begin
          s_axi_bresp <= err_recov_pkg::RESP_OKAY;
          if (wStrb_q[0]) begin
            cfg_q[7:0] <= wData_q[7:0];
          end
          if (wStrb_q[1]) begin
            cfg_q[12:8] <= wData_q[12:8];
          end
        end else if (awAddr_q == err_recov_pkg::STAT_OFS || awAddr_q == err_recov_pkg::REALLOC_OFS) begin
          s_axi_bresp <= err_recov_pkg::RESP_OKAY;
        end else begin
          s_axi_bresp <= err_recov_pkg::RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= err_recov_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= err_recov_pkg::RESP_OKAY;
      if (s_axi_araddr == err_recov_pkg::CFG_OFS) begin
        s_axi_rdata <= {19'h00000, cfg_q};
      end else if (s_axi_araddr == err_recov_pkg::STAT_OFS) begin
        s_axi_rdata <= {16'h0000, n_q, 3'h0, lastOut_q, state_q};
      end else if (s_axi_araddr == err_recov_pkg::REALLOC_OFS) begin
        s_axi_rdata <= {16'h0000, reallocCnt_q};
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= err_recov_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  logic cfgEarly;
  logic cfgAutoRR;
  logic cfgAutoWR;
  logic cfgReadCont;
  logic cfgDisCorr;
  assign cfgEarly = cfg_q[err_recov_pkg::CFG_EARLY_BIT];
  assign cfgAutoRR = cfg_q[err_recov_pkg::CFG_AUTO_RR_BIT];
  assign cfgAutoWR = cfg_q[err_recov_pkg::CFG_AUTO_WR_BIT];
  assign cfgReadCont = cfg_q[err_recov_pkg::CFG_READ_CONT_BIT];
  assign cfgDisCorr = cfg_q[err_recov_pkg::CFG_DIS_CORR_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // syndrome capture and stable detection
  syn_store_if #(.W(err_recov_pkg::SYN_W), .AW(1)) store();
  syndrome_store #(.W(err_recov_pkg::SYN_W), .AW(1)) u_store (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .port(store.mem)
  );

  logic slot_q;
  logic [err_recov_pkg::SYN_W-1:0] freshSyn;
  logic synZero;
  logic stable;
  assign freshSyn = freshCheck ^ storedCheck;
  assign store.wrEn = readDone && (state_q != err_recov_pkg::ST_ANALYZE);
  assign store.wrAddr = slot_q;
  assign store.wrData = freshSyn;
  assign store.rdAddr = !slot_q;
  assign synZero = (syndrome == '0);
  assign stable = (n_q != 8'h00) && (store.rdData == syndrome);

  ////////////////////////////////////////////////////////////////////////////
  // decision
  logic [31:0] waitCnt_q;
  logic timeout;
  logic decide;
  logic otf;
  logic dblOk;
  logic corrOk;
  logic [7:0] limit;
  logic [1:0] group;
  assign timeout = (waitCnt_q >= 32'(DECIDE_CYCLES));
  assign decide = (state_q == err_recov_pkg::ST_ANALYZE) && (synZero || anaValid || timeout);
  assign otf = !timeout && anaValid && (ilvMaxBytes <= err_recov_pkg::OTF_MAX_PER_ILV)
    && (errBits <= err_recov_pkg::OTF_MAX_BITS);
  assign dblOk = !timeout && anaValid && (ilvMaxBytes <= err_recov_pkg::DBL_MAX_PER_ILV)
    && (errBits <= err_recov_pkg::DBL_MAX_BITS);
  assign corrOk = dblOk && !cfgDisCorr;
  assign limit = (cfg_q[7:0] == 8'h00) ? 8'h00 : (cfgAutoRR ? err_recov_pkg::AUTO_RR_TRIES : cfg_q[7:0]);
  assign group = (n_q > 8'(2 * err_recov_pkg::GROUP_LEN)) ? 2'h3 : ((n_q > err_recov_pkg::GROUP_LEN) ? 2'h2 : 2'h1);

  logic finish;
  logic doReread;
  logic doRealloc;
  logic markBad;
  err_recov_pkg::corr_t kind;
  err_recov_pkg::outcome_t code;
  always_comb begin
    finish = 1'b1;
    doReread = 1'b0;
    doRealloc = 1'b0;
    markBad = 1'b0;
    kind = err_recov_pkg::CORR_NONE;
    code = err_recov_pkg::OUT_CLEAN;
    if (synZero) begin
      code = (n_q == 8'h00) ? err_recov_pkg::OUT_CLEAN : err_recov_pkg::OUT_RETRY;
    end else if (otf) begin
      kind = err_recov_pkg::CORR_OTF;
      code = (n_q == 8'h00) ? err_recov_pkg::OUT_OTF : err_recov_pkg::OUT_RETRY;
    end else if (cfgReadCont) begin
      code = err_recov_pkg::OUT_UNRECOV;
    end else if (n_q >= limit) begin
      if (corrOk) begin
        kind = err_recov_pkg::CORR_DOUBLE;
      end
      if (cfgAutoRR) begin
        doRealloc = 1'b1;
        markBad = !corrOk;
        code = corrOk ? err_recov_pkg::OUT_REALLOC : err_recov_pkg::OUT_UNRECOV;
      end else begin
        code = corrOk ? err_recov_pkg::OUT_RETRY : err_recov_pkg::OUT_UNRECOV;
      end
    end else if (cfgAutoRR && group == 2'h3 && (stable || corrOk)) begin
      doRealloc = 1'b1;
      markBad = !corrOk;
      kind = corrOk ? err_recov_pkg::CORR_DOUBLE : err_recov_pkg::CORR_NONE;
      // a flagged sector reads back as an error, so the host sees it unrecovered
      code = corrOk ? err_recov_pkg::OUT_REALLOC : err_recov_pkg::OUT_UNRECOV;
    end else if (cfgAutoRR && group == 2'h2 && stable && corrOk) begin
      doRealloc = 1'b1;
      kind = err_recov_pkg::CORR_DOUBLE;
      code = err_recov_pkg::OUT_REALLOC;
    end else if (!cfgAutoRR && cfgEarly && stable && corrOk) begin
      kind = err_recov_pkg::CORR_DOUBLE;
      code = err_recov_pkg::OUT_RETRY;
    end else begin
      finish = 1'b0;
      doReread = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= err_recov_pkg::ST_IDLE;
      n_q <= '0;
      slot_q <= 1'b0;
      waitCnt_q <= '0;
      syndrome <= '0;
    end else begin
      case (state_q)
        err_recov_pkg::ST_IDLE: begin
          if (readDone) begin
            state_q <= err_recov_pkg::ST_ANALYZE;
            n_q <= '0;
            syndrome <= freshSyn;
            waitCnt_q <= '0;
          end
        end
        err_recov_pkg::ST_ANALYZE: begin
          waitCnt_q <= waitCnt_q + 32'h1;
          if (decide) begin
            slot_q <= !slot_q;
            state_q <= finish ? err_recov_pkg::ST_IDLE : err_recov_pkg::ST_WAITREAD;
          end
        end
        err_recov_pkg::ST_WAITREAD: begin
          if (readDone) begin
            state_q <= err_recov_pkg::ST_ANALYZE;
            n_q <= n_q + 8'h1;
            syndrome <= freshSyn;
            waitCnt_q <= '0;
          end
        end
        default: state_q <= err_recov_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rereadReq <= 1'b0;
      corrReq <= 1'b0;
      corrKind <= err_recov_pkg::CORR_NONE;
      outValid <= 1'b0;
      outCode <= err_recov_pkg::OUT_CLEAN;
      lastOut_q <= err_recov_pkg::OUT_CLEAN;
    end else begin
      rereadReq <= decide && doReread;
      corrReq <= decide && (kind != err_recov_pkg::CORR_NONE);
      corrKind <= decide ? kind : err_recov_pkg::CORR_NONE;
      outValid <= decide && finish;
      if (decide && finish) begin
        outCode <= code;
        lastOut_q <= code;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // spare allocation
  logic [2:0] inlineCnt_q;
  logic wrPend_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      inlineCnt_q <= '0;
      wrPend_q <= 1'b0;
      spareReq <= 1'b0;
      spareInline <= 1'b0;
      spareGrown <= 1'b0;
      spareBad <= 1'b0;
      reallocCnt_q <= '0;
    end else begin
      spareReq <= 1'b0;
      spareInline <= 1'b0;
      spareGrown <= 1'b0;
      spareBad <= 1'b0;
      if (writeFail && cfgAutoWR) begin
        wrPend_q <= 1'b1;
      end
      if (cylinderNew) begin
        inlineCnt_q <= '0;
      end
      if (decide && doRealloc) begin
        spareReq <= 1'b1;
        spareGrown <= 1'b1;
        spareBad <= markBad;
        reallocCnt_q <= reallocCnt_q + 16'h1;
      end else if (wrPend_q) begin
        wrPend_q <= writeFail && cfgAutoWR;
        spareReq <= 1'b1;
        reallocCnt_q <= reallocCnt_q + 16'h1;
      end else if (factoryDefect) begin
        spareReq <= 1'b1;
        spareInline <= (inlineCnt_q < err_recov_pkg::INLINE_MAX);
        if (!cylinderNew && inlineCnt_q < err_recov_pkg::INLINE_MAX) begin
          inlineCnt_q <= inlineCnt_q + 3'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  reread_limit_a: assert property (rereadReq |-> $past(n_q) < $past(limit))
    else $error("reread issued beyond the retry limit");
  no_recovery_a: assert property (rereadReq |-> !$past(cfgReadCont))
    else $error("reread issued with read continuous set");
  decide_bound_a: assert property (state_q == err_recov_pkg::ST_ANALYZE |-> waitCnt_q <= 32'(DECIDE_CYCLES))
    else $error("correctability decision overran its time bound");
  double_ok_a: assert property (corrReq && corrKind == err_recov_pkg::CORR_DOUBLE
    |-> $past(ilvMaxBytes) <= 2'h2 && !$past(cfgDisCorr))
    else $error("double burst correction on uncorrectable or disabled");
  otf_extent_a: assert property (corrReq && corrKind == err_recov_pkg::CORR_OTF
    |-> $past(ilvMaxBytes) <= 2'h1 && $past(errBits) <= 7'h18)
    else $error("on-the-fly correction outside its extent");
  inline_cap_a: assert property (spareInline |-> $past(inlineCnt_q) < 3'h4)
    else $error("inline sparing beyond four per cylinder");
  grown_spare_a: assert property (spareGrown |-> !spareInline && $past(cfgAutoRR))
    else $error("grown defect inline spared or without auto reallocation");
  bad_flag_a: assert property (spareBad |-> spareGrown && outValid && outCode == err_recov_pkg::OUT_UNRECOV)
    else $error("bad flag without grown unrecoverable reallocation");
  zero_report_a: assert property (state_q == err_recov_pkg::ST_ANALYZE && synZero
    |=> outValid && !rereadReq)
    else $error("zero syndrome did not end the sector");
  reread_then_wait_a: assert property (rereadReq |-> state_q == err_recov_pkg::ST_WAITREAD)
    else $error("reread issued without waiting for the read");

  otf_seen_c: cover property (outValid && outCode == err_recov_pkg::OUT_OTF);
  realloc_seen_c: cover property (spareReq && spareGrown && !spareBad);
  unrecov_seen_c: cover property (outValid && outCode == err_recov_pkg::OUT_UNRECOV);
  stable_seen_c: cover property (state_q == err_recov_pkg::ST_ANALYZE && stable);
endmodule

// >>> design/err_recov_pkg.sv
// constants, types and register map of the read error recovery sequencer
// assumes a 100 MHz controller clock and an AXI4-Lite register slave
package err_recov_pkg;
  localparam int CLK_MHZ = 100;
  localparam int XCHK_BYTES = 2;
  localparam int ECC_BYTES = 12;
  localparam int SYN_BYTES = XCHK_BYTES + ECC_BYTES;
  localparam int SYN_W = SYN_BYTES * 8;
  localparam logic [6:0] OTF_MAX_BITS = 7'h18;
  localparam logic [6:0] DBL_MAX_BITS = 7'h30;
  localparam logic [1:0] OTF_MAX_PER_ILV = 2'h1;
  localparam logic [1:0] DBL_MAX_PER_ILV = 2'h2;
  localparam logic [7:0] GROUP_LEN = 8'h08;
  localparam logic [7:0] AUTO_RR_TRIES = 8'h18;
  localparam logic [2:0] INLINE_MAX = 3'h4;
  localparam int DECIDE_TIME_US = 200;
  localparam int DECIDE_CYC = DECIDE_TIME_US * CLK_MHZ;
  // register map
  localparam logic [3:0] CFG_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam logic [3:0] REALLOC_OFS = 4'h8;
  localparam logic [7:0] RETRY_RST = 8'h08;
  localparam int CFG_EARLY_BIT = 8;
  localparam int CFG_AUTO_RR_BIT = 9;
  localparam int CFG_AUTO_WR_BIT = 10;
  localparam int CFG_READ_CONT_BIT = 11;
  localparam int CFG_DIS_CORR_BIT = 12;
  localparam logic [12:0] CFG_RST = {5'h00, RETRY_RST};
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ANALYZE = 2'b01,
    ST_WAITREAD = 2'b11
  } state_t;
  typedef enum logic [2:0] {
    OUT_CLEAN = 3'h0,
    OUT_OTF = 3'h1,
    OUT_RETRY = 3'h2,
    OUT_REALLOC = 3'h3,
    OUT_UNRECOV = 3'h4
  } outcome_t;
  typedef enum logic [1:0] {
    CORR_NONE = 2'h0,
    CORR_OTF = 2'h1,
    CORR_DOUBLE = 2'h2
  } corr_t;
endpackage

// >>> design/syn_store_if.sv
// link between the sequencer and its syndrome store
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface syn_store_if #(parameter int W = 112, parameter int AW = 1);
  logic wrEn;
  logic [AW-1:0] wrAddr;
  logic [W-1:0] wrData;
  logic [AW-1:0] rdAddr;
  logic [W-1:0] rdData;
  modport seq (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
  modport mem (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface

// >>> design/syndrome_store.sv
// small memory holding syndrome sets of consecutive reads of one sector
// assumes one write port and one registered read port on one clock
`timescale 1ns/1ns
module syndrome_store #(
  parameter int W = 112,
  parameter int AW = 1
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  syn_store_if.mem port
);
  logic [W-1:0] mem_q [2**AW];
  logic [W-1:0] rdData_q;

  always_ff @(posedge clk_sys) begin
    if (port.wrEn) begin
      mem_q[port.wrAddr] <= port.wrData;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdData_q <= '0;
    end else begin
      rdData_q <= mem_q[port.rdAddr];
    end
  end

  assign port.rdData = rdData_q;
endmodule

// >>> testbench/read_channel_model.sv
// model of the read channel and syndrome analyser beside the sequencer
// assumes the testbench starts each sector with go and sets the error picture
`timescale 1ns/1ns
module read_channel_model (
  input wire logic clk_sys,
  input wire logic go,
  input wire logic rereadReq,
  input wire logic [7:0] cleanAt,
  input wire logic stab,
  input wire logic [1:0] ilv,
  input wire logic [6:0] bits,
  input wire logic mute,
  output logic readDone,
  output logic [err_recov_pkg::SYN_W-1:0] freshCheck,
  output logic [err_recov_pkg::SYN_W-1:0] storedCheck,
  output logic anaValid,
  output logic [1:0] ilvMaxBytes,
  output logic [6:0] errBits
);
  localparam logic [111:0] BASE = {7{16'hA5C3}};
  localparam logic [111:0] FLAW = {14{8'h11}};
  logic [7:0] idx = 8'h00;
  int lag = 0;
  initial begin
    readDone = 1'b0;
    anaValid = 1'b0;
    freshCheck = BASE;
    storedCheck = BASE;
    ilvMaxBytes = 2'h0;
    errBits = 7'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  // odd reads answer slowly; qualified lines scramble when not valid
  always @(posedge clk_sys) begin
    readDone <= 1'b0;
    // mute holds the analyser back so the decision has to time out
    anaValid <= readDone && !mute;
    ilvMaxBytes <= readDone ? ilv : ~ilvMaxBytes;
    errBits <= readDone ? bits : ~errBits;
    freshCheck <= ~freshCheck;
    storedCheck <= ~storedCheck;
    if (go) begin
      idx <= 8'h00;
    end
    if (go || rereadReq) begin
      lag <= 1 + 2 * int'(idx[0]);
    end else if (lag > 0) begin
      lag <= lag - 1;
      if (lag == 1) begin
        readDone <= 1'b1;
        storedCheck <= BASE;
        // stable sets repeat the flaw, others vary with the read index
        freshCheck <= BASE ^ ((idx >= cleanAt) ? '0 : (stab ? FLAW : {FLAW[111:8], FLAW[7:0] ^ idx}));
        idx <= idx + 8'h01;
      end
    end
  end
endmodule

// >>> testbench/tb.sv
// self-checking bench of the read error recovery sequencer
// assumes the read channel model and the design package are compiled first
`timescale 1ns/1ns
module tb;
  typedef struct packed {
    logic [12:0] cfg;
    logic [7:0] clean;
    logic stab;
    logic [1:0] ilv;
    logic [6:0] bits;
    logic [2:0] code;
    logic [7:0] nrr;
    logic bad;
  } row_t;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, ilvMaxBytes, corrKind, ilv = 2'h0;
  logic readDone, anaValid, rereadReq, corrReq, spareReq, spareInline;
  logic spareGrown, spareBad, outValid, stab = 1'b0, go = 1'b0, mute = 1'b0;
  logic writeFail = 1'b0, factoryDefect = 1'b0, cylinderNew = 1'b0;
  logic [111:0] freshCheck, storedCheck, syndrome;
  logic [6:0] errBits, bits = 7'h00;
  logic [7:0] cleanAt = 8'h00;
  logic [2:0] outCode, lastCode = 3'h7;
  logic [31:0] q;
  logic [1:0] r;
  int nErrors = 0, testsRun = 0, nOut = 0, nRr = 0, nBad = 0, nInl = 0, nSpare = 0, nDbl = 0, nOtf = 0;
  int b0, b1, b2;
  row_t rows[14] = '{
    '{13'h008, 8'h63, 1'b0, 2'h1, 7'h18, 3'h4, 8'h08, 1'b0},
    '{13'h008, 8'h00, 1'b0, 2'h1, 7'h18, 3'h0, 8'h00, 1'b0},
    '{13'h008, 8'h09, 1'b0, 2'h1, 7'h18, 3'h1, 8'h00, 1'b0},
    '{13'h008, 8'h03, 1'b0, 2'h2, 7'h30, 3'h2, 8'h03, 1'b0},
    '{13'h008, 8'h63, 1'b0, 2'h2, 7'h30, 3'h2, 8'h08, 1'b0},
    '{13'h000, 8'h63, 1'b0, 2'h2, 7'h30, 3'h2, 8'h00, 1'b0},
    '{13'h808, 8'h63, 1'b0, 2'h2, 7'h30, 3'h4, 8'h00, 1'b0},
    '{13'h108, 8'h63, 1'b1, 2'h2, 7'h30, 3'h2, 8'h01, 1'b0},
    '{13'h108, 8'h63, 1'b1, 2'h3, 7'h30, 3'h4, 8'h08, 1'b0},
    '{13'h208, 8'h63, 1'b1, 2'h2, 7'h30, 3'h3, 8'h09, 1'b0},
    '{13'h208, 8'h63, 1'b1, 2'h3, 7'h30, 3'h4, 8'h11, 1'b1},
    '{13'h208, 8'h63, 1'b0, 2'h3, 7'h30, 3'h4, 8'h18, 1'b1},
    '{13'h1008, 8'h63, 1'b0, 2'h2, 7'h30, 3'h4, 8'h08, 1'b0},
    '{13'h1008, 8'h09, 1'b0, 2'h1, 7'h18, 3'h1, 8'h00, 1'b0}
  };
  always #5 clk_sys = ~clk_sys;
  disk_read_error_recovery #(.DECIDE_CYCLES(20)) u_dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .readDone(readDone),
    .freshCheck(freshCheck), .storedCheck(storedCheck), .anaValid(anaValid),
    .ilvMaxBytes(ilvMaxBytes), .errBits(errBits), .writeFail(writeFail),
    .factoryDefect(factoryDefect), .cylinderNew(cylinderNew), .rereadReq(rereadReq),
    .corrReq(corrReq), .corrKind(corrKind), .spareReq(spareReq), .spareInline(spareInline),
    .spareGrown(spareGrown), .spareBad(spareBad), .outValid(outValid), .outCode(outCode),
    .syndrome(syndrome));
  read_channel_model u_model (.clk_sys(clk_sys), .go(go), .rereadReq(rereadReq),
    .cleanAt(cleanAt), .stab(stab), .ilv(ilv), .bits(bits), .mute(mute), .readDone(readDone),
    .freshCheck(freshCheck), .storedCheck(storedCheck), .anaValid(anaValid),
    .ilvMaxBytes(ilvMaxBytes), .errBits(errBits));
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    if (outValid) begin
      lastCode <= outCode;
    end
    nOut <= nOut + int'(outValid);
    nRr <= nRr + int'(rereadReq);
    nBad <= nBad + int'(spareReq && spareBad);
    nInl <= nInl + int'(spareReq && spareInline);
    nSpare <= nSpare + int'(spareReq);
    nDbl <= nDbl + int'(corrReq && corrKind == err_recov_pkg::CORR_DOUBLE);
    nOtf <= nOtf + int'(corrReq && corrKind == err_recov_pkg::CORR_OTF);
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic testDone();
    $display("checks %0d mismatches %0d", testsRun, nErrors);
    if (nErrors == 0 && testsRun > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    testsRun++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
      nErrors++;
    end
  endtask
  // one write or read; each channel released at the edge that takes it
  task automatic axi(input bit wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    bit ta, tw, fin;
    n = 0;
    fin = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    while (!fin && n < 100) begin
      @(negedge clk_sys);
      ta = (s_axi_awvalid && s_axi_awready) || (s_axi_arvalid && s_axi_arready);
      tw = s_axi_wvalid && s_axi_wready;
      fin = wr ? s_axi_bvalid : s_axi_rvalid;
      r = wr ? s_axi_bresp : s_axi_rresp;
      q = s_axi_rdata;
      @(posedge clk_sys);
      if (ta) begin
        s_axi_awvalid <= 1'b0;
        s_axi_arvalid <= 1'b0;
      end
      if (tw) begin
        s_axi_wvalid <= 1'b0;
      end
      n++;
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    if (!fin) begin
      chk("bus answer", 32'h1, 32'h0);
      testDone();
    end
  endtask
  // one-cycle strobe: 0 go, 1 factory defect, 2 new cylinder, 3 write failure
  task automatic pulse(input int w);
    go <= (w == 0);
    factoryDefect <= (w == 1);
    cylinderNew <= (w == 2);
    writeFail <= (w == 3);
    @(posedge clk_sys);
    go <= 1'b0;
    factoryDefect <= 1'b0;
    cylinderNew <= 1'b0;
    writeFail <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    axi(0, err_recov_pkg::CFG_OFS, 32'h0);
    chk("cfg reset", 32'h8, q);
    axi(0, 4'hC, 32'h0);
    chk("unmapped resp", 32'(err_recov_pkg::RESP_SLVERR), 32'(r));
    axi(1, err_recov_pkg::STAT_OFS, 32'hFFFF);
    chk("stat write resp", 32'(err_recov_pkg::RESP_OKAY), 32'(r));
    for (int i = 0; i < 14; i++) begin
      axi(1, err_recov_pkg::CFG_OFS, 32'(rows[i].cfg));
      cleanAt <= rows[i].clean;
      stab <= rows[i].stab;
      ilv <= rows[i].ilv;
      bits <= rows[i].bits;
      mute <= (i == 0);
      b0 = nOut;
      b1 = nRr;
      b2 = nBad;
      pulse(0);
      for (int n = 0; n < 3000 && nOut == b0; n++) begin
        @(posedge clk_sys);
      end
      if (nOut == b0) begin
        chk("sector end", 32'h1, 32'h0);
        testDone();
      end
      chk("outcome", 32'(rows[i].code), 32'(lastCode));
      chk("rereads", 32'(rows[i].nrr), 32'(nRr - b1));
      chk("bad marks", 32'(rows[i].bad), 32'(nBad - b2));
    end
    chk("syndrome", {8'h11, 8'h11, 8'h11, 8'h11}, syndrome[31:0]);
    chk("double corrections", 32'h4, 32'(nDbl));
    chk("otf corrections", 32'h2, 32'(nOtf));
    axi(0, err_recov_pkg::STAT_OFS, 32'h0);
    chk("status", 32'h4, q);
    chk("inline in recovery", 32'h0, 32'(nInl));
    b1 = nSpare;
    repeat (5) pulse(1);
    chk("inline spares", 32'h4, 32'(nInl));
    pulse(2);
    pulse(1);
    chk("inline after new cylinder", 32'h5, 32'(nInl));
    chk("factory spares", 32'h6, 32'(nSpare - b1));
    axi(1, err_recov_pkg::CFG_OFS, 32'h408);
    b1 = nSpare;
    pulse(3);
    chk("write realloc", 32'h1, 32'(nSpare - b1));
    axi(0, err_recov_pkg::REALLOC_OFS, 32'h0);
    chk("realloc count", 32'h4, q);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    axi(0, err_recov_pkg::CFG_OFS, 32'h0);
    chk("cfg after reset", 32'h8, q);
    axi(0, err_recov_pkg::REALLOC_OFS, 32'h0);
    chk("realloc after reset", 32'h0, q);
    testDone();
  end
endmodule
